// ---- rtl/csrf_pkg.sv ----
// constants for the context state and rectangle fill block
package csrf_pkg;
  // method offsets
  localparam logic [11:0] MTH_PATCH   = 12'h200;
  localparam logic [11:0] MTH_SET     = 12'h300;
  localparam logic [11:0] MTH_COLOR   = 12'h304;
  localparam logic [11:0] MTH_DRAW_XY = 12'h400;
  localparam logic [11:0] MTH_DRAW_WH = 12'h404;
  localparam logic [4:0]  DRAW_WIN    = 5'h08;
  localparam logic [31:0] WEIGHT_SIGN = 32'h8000_0000;
  localparam logic [31:0] WEIGHT_MASK = 32'h7f80_0000;
  localparam logic [31:0] ROP_HIGH    = 32'hffff_ff00;
  localparam logic [7:0]  ROP_COPY    = 8'hcc;

  typedef enum logic [2:0] {OBJ_WEIGHT, OBJ_ROP, OBJ_KEY, OBJ_PLANE,
                            OBJ_CLIP, OBJ_CH_WEIGHT, OBJ_RECT, OBJ_POINT} csrf_obj_e;

  localparam logic [1:0] ERR_NONE    = 2'h0;
  localparam logic [1:0] ERR_MISSING = 2'h1;
  localparam logic [1:0] ERR_BAD_VAL = 2'h2;

  // register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_CANVAS_MIN = 8'h04;
  localparam logic [7:0] REG_CANVAS_MAX = 8'h08;
  localparam logic [7:0] REG_FILL       = 8'h0c;
  localparam logic [7:0] REG_STATUS     = 8'h10;
  localparam logic [7:0] REG_WEIGHT     = 8'h14;
  localparam logic [7:0] REG_ROP        = 8'h18;
  localparam logic [7:0] REG_CLIP_MIN   = 8'h1c;
  localparam logic [7:0] REG_CLIP_MAX   = 8'h20;
  localparam logic [7:0] REG_UCLIP_MIN  = 8'h24;
  localparam logic [7:0] REG_UCLIP_MAX  = 8'h28;
  localparam logic [7:0] REG_KEY        = 8'h2c;
  localparam logic [7:0] REG_PLANE      = 8'h30;
  localparam logic [7:0] REG_CH_WEIGHT  = 8'h34;

  // control fields
  localparam int CTRL_UCLIP = 0;
  localparam int CTRL_KEY   = 1;
  localparam int CTRL_PLANE = 2;
  localparam int CTRL_MODE  = 4;
  localparam logic [2:0] MODE_ROP_AND = 3'h1;
  localparam logic [2:0] MODE_ROP_SRC = 3'h4;

  localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
  localparam logic [31:0] RST_CANVAS_MAX = 32'hffff_ffff;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/csrf_clip_window.sv ----
// final clip window from canvas and user clip
`timescale 1ns/10ps
module csrf_clip_window (
  input  wire logic        uclip_en_i,
  input  wire logic [31:0] canvas_min_i,
  input  wire logic [31:0] canvas_max_i,
  input  wire logic [15:0] uclip_left_i,
  input  wire logic [15:0] uclip_top_i,
  input  wire logic [15:0] uclip_right_i,
  input  wire logic [15:0] uclip_bottom_i,
  output logic      [15:0] clip_left_o,
  output logic      [15:0] clip_top_o,
  output logic      [15:0] clip_right_o,
  output logic      [15:0] clip_bottom_o
);
  function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
    max16 = (a > b) ? a : b;
  endfunction

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  assign clip_left_o   = uclip_en_i ? max16(uclip_left_i, canvas_min_i[15:0]) : canvas_min_i[15:0];
  assign clip_top_o    = uclip_en_i ? max16(uclip_top_i, canvas_min_i[31:16]) : canvas_min_i[31:16];
  assign clip_right_o  = uclip_en_i ? min16(uclip_right_i, canvas_max_i[15:0]) : canvas_max_i[15:0];
  assign clip_bottom_o = uclip_en_i ? min16(uclip_bottom_i, canvas_max_i[31:16]) : canvas_max_i[31:16];
endmodule

// ---- rtl/csrf_rect_raster.sv ----
// solid rectangle rasteriser, one pixel per accepted beat
`timescale 1ns/10ps
module csrf_rect_raster (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] x_i,
  input  wire logic [15:0] y_i,
  input  wire logic [15:0] w_i,
  input  wire logic [15:0] h_i,
  input  wire logic [15:0] clip_left_i,
  input  wire logic [15:0] clip_top_i,
  input  wire logic [15:0] clip_right_i,
  input  wire logic [15:0] clip_bottom_i,
  input  wire logic        pix_ready_i,
  output logic             pix_valid_o,
  output logic      [15:0] pix_x_o,
  output logic      [15:0] pix_y_o,
  output logic             busy_o
);
  typedef enum logic {RS_IDLE, RS_RUN} csrf_rs_e;
  csrf_rs_e    state;
  logic [16:0] left;
  logic [16:0] right;
  logic [16:0] bottom;
  logic [16:0] cur_x;
  logic [16:0] cur_y;

  function automatic logic [16:0] max17(input logic [16:0] a, input logic [16:0] b);
    max17 = (a > b) ? a : b;
  endfunction

  function automatic logic [16:0] min17(input logic [16:0] a, input logic [16:0] b);
    min17 = (a < b) ? a : b;
  endfunction

  // edges kept 17 bits wide so x+w never wraps
  wire [16:0] next_l = max17({1'b0, x_i}, {1'b0, clip_left_i});
  wire [16:0] next_r = min17({1'b0, x_i} + {1'b0, w_i}, {1'b0, clip_right_i});
  wire [16:0] next_t = max17({1'b0, y_i}, {1'b0, clip_top_i});
  wire [16:0] next_b = min17({1'b0, y_i} + {1'b0, h_i}, {1'b0, clip_bottom_i});
  wire        empty  = (next_l >= next_r) || (next_t >= next_b);
  wire        beat   = (state == RS_RUN) && pix_ready_i;
  wire        row_end = (cur_x + 17'h1) == right;

  assign pix_valid_o = (state == RS_RUN);
  assign busy_o      = (state == RS_RUN);
  assign pix_x_o     = cur_x[15:0];
  assign pix_y_o     = cur_y[15:0];

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state  <= RS_IDLE;
      left   <= 17'h0;
      right  <= 17'h0;
      bottom <= 17'h0;
      cur_x  <= 17'h0;
      cur_y  <= 17'h0;
    end
    else if (state == RS_IDLE && start_i && !empty)
    begin
      state  <= RS_RUN;
      left   <= next_l;
      right  <= next_r;
      bottom <= next_b;
      cur_x  <= next_l;
      cur_y  <= next_t;
    end
    else if (beat)
    begin
      // top to bottom, left to right
      cur_x <= row_end ? left : cur_x + 17'h1;
      cur_y <= row_end ? cur_y + 17'h1 : cur_y;
      if (row_end && (cur_y + 17'h1) == bottom)
        state <= RS_IDLE;
    end
  end
endmodule

// ---- rtl/csrf_context.sv ----
// context state method interpreter with rectangle and point fill
//
// Notes on behaviour
// - negative blend weight stored as zero
// - positive weight masked to eight fractional bits
// - raster-op above eight bits is bad value
// - raster-op code used only in raster-op modes
// - patch output methods raise missing method
// - key and mask colors stored A1R10G10B10
// - color key applied only when enabled
// - plane mask applied only when enabled
// - corner: max to min, max gets canvas+xy
// - size: max to min, max grows by wh
// - user clip kept in absolute coordinates
// - user clip used only when enabled
// - per-channel weight bytes blue to alpha
// - final left/top is max when enabled
// - final right/bottom is min when enabled
// - rectangle covers X..X+W-1, Y..Y+H-1
// - clamp to clip, emit rows top down
// - integer coordinates only, no subpixel
// - point is a one by one rectangle
`timescale 1ns/10ps
module csrf_context (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // method port
  input  wire logic        mth_valid_i,
  input  wire logic [2:0]  mth_obj_i,
  input  wire logic [11:0] mth_offset_i,
  input  wire logic [31:0] mth_param_i,
  output logic             mth_ready_o,
  output logic             err_valid_o,
  output logic      [1:0]  err_code_o,
  // pixel writes
  output logic             pix_valid_o,
  input  wire logic        pix_ready_i,
  output logic      [15:0] pix_x_o,
  output logic      [15:0] pix_y_o,
  output logic      [31:0] pix_color_o,
  output logic      [7:0]  pix_rop_o,
  output logic             pix_key_en_o,
  output logic      [30:0] pix_key_color_o,
  output logic             pix_plane_en_o,
  output logic      [30:0] pix_plane_color_o,
  output logic             busy_o,
  // axi4-lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp
);

  // **********
  // state
  // **********
  logic [31:0] ctrl;
  logic [31:0] canvas_min;
  logic [31:0] canvas_max;
  logic [31:0] fill_color;
  logic [31:0] weight;
  logic [7:0]  rop_code;
  logic [30:0] key_color;
  logic [30:0] plane_color;
  logic [31:0] ch_weight;
  logic [15:0] uclip_left;
  logic [15:0] uclip_top;
  logic [15:0] uclip_right;
  logic [15:0] uclip_bottom;
  logic [15:0] rect_x;
  logic [15:0] rect_y;
  logic [15:0] clip_left;
  logic [15:0] clip_top;
  logic [15:0] clip_right;
  logic [15:0] clip_bottom;
  logic        raster_busy;

  function automatic logic [30:0] to_a1r10(input logic [31:0] p);
    // 8-bit channels widened by repeating their top bits
    to_a1r10 = {p[31], p[23:16], p[23:22], p[15:8], p[15:14], p[7:0], p[7:6]};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = {s[3] ? d[31:24] : old[31:24], s[2] ? d[23:16] : old[23:16],
             s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // **********
  // method decode
  // **********
  wire        take      = mth_valid_i && mth_ready_o;
  wire        obj_weight = mth_obj_i == csrf_pkg::OBJ_WEIGHT;
  wire        obj_rop   = mth_obj_i == csrf_pkg::OBJ_ROP;
  wire        obj_key   = mth_obj_i == csrf_pkg::OBJ_KEY;
  wire        obj_plane = mth_obj_i == csrf_pkg::OBJ_PLANE;
  wire        obj_clip  = mth_obj_i == csrf_pkg::OBJ_CLIP;
  wire        obj_chw   = mth_obj_i == csrf_pkg::OBJ_CH_WEIGHT;
  wire        obj_rect  = mth_obj_i == csrf_pkg::OBJ_RECT;
  wire        obj_point = mth_obj_i == csrf_pkg::OBJ_POINT;
  wire        at_set    = mth_offset_i == csrf_pkg::MTH_SET;
  wire        at_color  = mth_offset_i == csrf_pkg::MTH_COLOR;
  wire        in_draw   = mth_offset_i[11:7] == csrf_pkg::DRAW_WIN && mth_offset_i[1:0] == 2'h0;
  wire        draw_wh   = mth_offset_i[2] == csrf_pkg::MTH_DRAW_WH[2];

  wire do_weight = take && obj_weight && at_set;
  wire do_rop    = take && obj_rop && at_set;
  wire rop_bad   = (mth_param_i & csrf_pkg::ROP_HIGH) != 32'h0;
  wire do_key    = take && obj_key && at_color;
  wire do_plane  = take && obj_plane && at_color;
  wire do_corner = take && obj_clip && at_set;
  wire do_size   = take && obj_clip && at_color;
  wire do_chw    = take && obj_chw && at_set;
  wire do_rxy    = take && obj_rect && in_draw && !draw_wh;
  wire do_rwh    = take && obj_rect && in_draw && draw_wh;
  wire do_point  = take && obj_point && in_draw;

  // anything not decoded above, the patch offsets among them, is missing
  wire known = (obj_weight && at_set) || (obj_rop && at_set) || ((obj_key || obj_plane) && at_color)
               || (obj_clip && (at_set || at_color)) || (obj_chw && at_set) || ((obj_rect || obj_point) && in_draw);
  wire err_missing = take && !known;
  wire err_bad     = do_rop && rop_bad;

  // one method at a time; the fill owns the pipe until its last pixel
  assign mth_ready_o = !raster_busy;
  assign busy_o      = raster_busy;

  // integer corners only, the draw coordinates feed the raster directly
  wire        start   = do_rwh || do_point;
  wire [15:0] draw_x  = do_point ? mth_param_i[15:0] : rect_x;
  wire [15:0] draw_y  = do_point ? mth_param_i[31:16] : rect_y;
  wire [15:0] draw_w  = do_point ? 16'h1 : mth_param_i[15:0];
  wire [15:0] draw_h  = do_point ? 16'h1 : mth_param_i[31:16];

  // **********
  // method state updates
  // **********
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      weight      <= 32'h0;
      rop_code    <= csrf_pkg::ROP_COPY;
      key_color   <= 31'h0;
      plane_color <= 31'h0;
      ch_weight   <= 32'h0;
      rect_x      <= 16'h0;
      rect_y      <= 16'h0;
    end
    else
    begin
      if (do_weight)
        weight <= (mth_param_i & csrf_pkg::WEIGHT_SIGN) != 32'h0 ? 32'h0
                  : mth_param_i & csrf_pkg::WEIGHT_MASK;
      if (do_rop && !rop_bad)
        rop_code <= mth_param_i[7:0];
      if (do_key)
        key_color <= to_a1r10(mth_param_i);
      if (do_plane)
        plane_color <= to_a1r10(mth_param_i);
      if (do_chw)
        ch_weight <= {mth_param_i[31:24], mth_param_i[23:16], mth_param_i[15:8], mth_param_i[7:0]};
      if (do_rxy)
      begin
        rect_x <= mth_param_i[15:0];
        rect_y <= mth_param_i[31:16];
      end
    end
  end

  // user clip held in framebuffer coordinates
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      uclip_left   <= 16'h0;
      uclip_top    <= 16'h0;
      uclip_right  <= 16'h0;
      uclip_bottom <= 16'h0;
    end
    else if (do_corner || do_size)
    begin
      uclip_left   <= uclip_right;
      uclip_top    <= uclip_bottom;
      uclip_right  <= (do_corner ? canvas_min[15:0] : uclip_right) + mth_param_i[15:0];
      uclip_bottom <= (do_corner ? canvas_min[31:16] : uclip_bottom) + mth_param_i[31:16];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      err_valid_o <= 1'b0;
      err_code_o  <= csrf_pkg::ERR_NONE;
    end
    else
    begin
      err_valid_o <= err_missing || err_bad;
      err_code_o  <= err_missing ? csrf_pkg::ERR_MISSING
                   : err_bad ? csrf_pkg::ERR_BAD_VAL : csrf_pkg::ERR_NONE;
    end
  end

  // **********
  // clip window and fill
  // **********
  csrf_clip_window u_clip (
    .uclip_en_i     (ctrl[csrf_pkg::CTRL_UCLIP]),
    .canvas_min_i   (canvas_min),
    .canvas_max_i   (canvas_max),
    .uclip_left_i   (uclip_left),
    .uclip_top_i    (uclip_top),
    .uclip_right_i  (uclip_right),
    .uclip_bottom_i (uclip_bottom),
    .clip_left_o    (clip_left),
    .clip_top_o     (clip_top),
    .clip_right_o   (clip_right),
    .clip_bottom_o  (clip_bottom)
  );

  csrf_rect_raster u_raster (
    .sys_clk_i     (sys_clk_i),
    .nrst_i        (nrst_i),
    .start_i       (start),
    .x_i           (draw_x),
    .y_i           (draw_y),
    .w_i           (draw_w),
    .h_i           (draw_h),
    .clip_left_i   (clip_left),
    .clip_top_i    (clip_top),
    .clip_right_i  (clip_right),
    .clip_bottom_i (clip_bottom),
    .pix_ready_i   (pix_ready_i),
    .pix_valid_o   (pix_valid_o),
    .pix_x_o       (pix_x_o),
    .pix_y_o       (pix_y_o),
    .busy_o        (raster_busy)
  );

  wire [2:0] mode    = ctrl[csrf_pkg::CTRL_MODE +: 3];
  wire       rop_mode = mode == csrf_pkg::MODE_ROP_AND || mode == csrf_pkg::MODE_ROP_SRC;

  // fill color and ops come from flops that cannot change while busy
  assign pix_color_o       = fill_color;
  assign pix_rop_o         = rop_mode ? rop_code : csrf_pkg::ROP_COPY;
  assign pix_key_en_o      = ctrl[csrf_pkg::CTRL_KEY];
  assign pix_key_color_o   = key_color;
  assign pix_plane_en_o    = ctrl[csrf_pkg::CTRL_PLANE];
  assign pix_plane_color_o = plane_color;

  // **********
  // axi4-lite slave
  // **********
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire wr_go  = aw_held && w_held && !s_axi_bvalid;
  wire wr_cfg = aw_addr == csrf_pkg::REG_CTRL || aw_addr == csrf_pkg::REG_CANVAS_MIN
                || aw_addr == csrf_pkg::REG_CANVAS_MAX || aw_addr == csrf_pkg::REG_FILL;
  // config writes wait while a fill is running so pixels stay consistent
  wire wr_do  = wr_go && wr_cfg && !raster_busy;
  wire wr_err = wr_go && !wr_cfg;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  function automatic logic [32:0] rd_mux(input logic [7:0] a);
    // bit 32 flags an unmapped address
    case (a)
      csrf_pkg::REG_CTRL:       rd_mux = {1'b0, ctrl};
      csrf_pkg::REG_CANVAS_MIN: rd_mux = {1'b0, canvas_min};
      csrf_pkg::REG_CANVAS_MAX: rd_mux = {1'b0, canvas_max};
      csrf_pkg::REG_FILL:       rd_mux = {1'b0, fill_color};
      csrf_pkg::REG_STATUS:     rd_mux = {32'h0, raster_busy};
      csrf_pkg::REG_WEIGHT:     rd_mux = {1'b0, weight};
      csrf_pkg::REG_ROP:        rd_mux = {25'h0, rop_code};
      csrf_pkg::REG_CLIP_MIN:   rd_mux = {1'b0, clip_top, clip_left};
      csrf_pkg::REG_CLIP_MAX:   rd_mux = {1'b0, clip_bottom, clip_right};
      csrf_pkg::REG_UCLIP_MIN:  rd_mux = {1'b0, uclip_top, uclip_left};
      csrf_pkg::REG_UCLIP_MAX:  rd_mux = {1'b0, uclip_bottom, uclip_right};
      csrf_pkg::REG_KEY:        rd_mux = {2'h0, key_color};
      csrf_pkg::REG_PLANE:      rd_mux = {2'h0, plane_color};
      csrf_pkg::REG_CH_WEIGHT:  rd_mux = {1'b0, ch_weight};
      default:                  rd_mux = {1'b1, 32'h0};
    endcase
  endfunction

  // procedural so a register change reruns the mux, not only a new address
  logic [32:0] rd_word;
  always_comb rd_word = rd_mux(s_axi_araddr);

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= csrf_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do || wr_err)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? csrf_pkg::RESP_SLVERR : csrf_pkg::RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl       <= csrf_pkg::RST_CTRL;
      canvas_min <= 32'h0;
      canvas_max <= csrf_pkg::RST_CANVAS_MAX;
      fill_color <= 32'h0;
    end
    else if (wr_do)
    begin
      if (aw_addr == csrf_pkg::REG_CTRL)
        ctrl <= merge(ctrl, w_data, w_strb);
      if (aw_addr == csrf_pkg::REG_CANVAS_MIN)
        canvas_min <= merge(canvas_min, w_data, w_strb);
      if (aw_addr == csrf_pkg::REG_CANVAS_MAX)
        canvas_max <= merge(canvas_max, w_data, w_strb);
      if (aw_addr == csrf_pkg::REG_FILL)
        fill_color <= merge(fill_color, w_data, w_strb);
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= csrf_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word[31:0];
      s_axi_rresp  <= rd_word[32] ? csrf_pkg::RESP_SLVERR : csrf_pkg::RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ---- sim/csrf_monitor.sv ----
// checker for method and pixel ports
`timescale 1ns/10ps
module csrf_monitor (
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic        mth_valid_i,
  input wire logic [2:0]  mth_obj_i,
  input wire logic [11:0] mth_offset_i,
  input wire logic [31:0] mth_param_i,
  input wire logic        mth_ready_o,
  input wire logic        err_valid_o,
  input wire logic [1:0]  err_code_o,
  input wire logic        pix_valid_o,
  input wire logic        pix_ready_i,
  input wire logic [15:0] pix_x_o,
  input wire logic [15:0] pix_y_o,
  input wire logic        busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  wire taken = mth_valid_i && mth_ready_o;
  property p_ready; mth_ready_o == !busy_o; endproperty
  a_ready: assert property (p_ready) else $error("ready vs busy");
  property p_pix_busy; pix_valid_o |-> busy_o; endproperty
  a_pix_busy: assert property (p_pix_busy) else $error("pixel idle");
  property p_hold; pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_x_o) && $stable(pix_y_o); endproperty
  a_hold: assert property (p_hold) else $error("pixel not held");
  property p_order;
    pix_valid_o && pix_ready_i |=> !pix_valid_o || pix_y_o == $past(pix_y_o) + 16'h1
      || (pix_y_o == $past(pix_y_o) && pix_x_o == $past(pix_x_o) + 16'h1);
  endproperty
  a_order: assert property (p_order) else $error("pixel order");
  property p_rop_bad;
    taken && mth_obj_i == csrf_pkg::OBJ_ROP && mth_offset_i == csrf_pkg::MTH_SET
      && |(mth_param_i & csrf_pkg::ROP_HIGH) |=> err_valid_o && err_code_o == csrf_pkg::ERR_BAD_VAL;
  endproperty
  a_rop_bad: assert property (p_rop_bad) else $error("rop not refused");
  property p_patch; taken && mth_offset_i == csrf_pkg::MTH_PATCH |=> err_valid_o && err_code_o == 2'h1; endproperty
  a_patch: assert property (p_patch) else $error("patch not refused");
  property p_err_cause; err_valid_o |-> $past(taken) && err_code_o != 2'h0; endproperty
  a_err_cause: assert property (p_err_cause) else $error("stray error");
  property p_weight; taken && mth_obj_i == csrf_pkg::OBJ_WEIGHT && mth_offset_i == 12'h300 |=> !err_valid_o; endproperty
  a_weight: assert property (p_weight) else $error("weight refused");
endmodule
bind csrf_context csrf_monitor csrf_monitor_inst (.*);

// ---- sim/csrf_issuer.sv ----
// method issuer model for the front end
`timescale 1ns/10ps
module csrf_issuer (
  input  wire logic        sys_clk_i,
  input  wire logic        mth_ready_i,
  output logic             mth_valid_o,
  output logic      [2:0]  mth_obj_o,
  output logic      [11:0] mth_offset_o,
  output logic      [31:0] mth_param_o
);
  initial {mth_valid_o, mth_obj_o, mth_offset_o, mth_param_o} = '0;
  // call after an edge; one idle edge follows
  task automatic send(input logic [2:0] o, input logic [11:0] f, input logic [31:0] p);
    mth_valid_o  <= 1'b1;
    mth_obj_o    <= o;
    mth_offset_o <= f;
    mth_param_o  <= p;
    do @(posedge sys_clk_i); while (!mth_ready_i);
    mth_valid_o <= 1'b0;
    // released param line carries junk, not the last value; object and offset keep theirs
    mth_param_o <= ~p;
    @(posedge sys_clk_i);
  endtask
endmodule

// ---- sim/tb.sv ----
// bench for the context block
`timescale 1ns/10ps
module tb;
  logic        sys_clk_i, nrst_i, pix_ready_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, fill;
  logic [3:0]  s_axi_wstrb;
  wire         mth_valid_i, mth_ready_o, err_valid_o, pix_valid_o, pix_key_en_o, pix_plane_en_o, busy_o;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [2:0]  mth_obj_i;
  wire  [11:0] mth_offset_i;
  wire  [31:0] mth_param_i, pix_color_o, s_axi_rdata;
  wire  [1:0]  err_code_o, s_axi_bresp, s_axi_rresp;
  wire  [15:0] pix_x_o, pix_y_o;
  wire  [7:0]  pix_rop_o;
  wire  [30:0] pix_key_color_o, pix_plane_color_o;
  logic [1:0]  last_err;
  logic [63:0] got[$], exp_q[$];
  logic [15:0] cl, ct, cr, cb;
  int          failures, checks_done, n_err, n0;
  csrf_context csrf_context_inst (.*);
  csrf_issuer csrf_issuer_inst (.sys_clk_i(sys_clk_i), .mth_ready_i(mth_ready_o), .mth_valid_o(mth_valid_i),
    .mth_obj_o(mth_obj_i), .mth_offset_o(mth_offset_i), .mth_param_o(mth_param_i));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // sink stalls every other cycle
  always @(posedge sys_clk_i)
  begin
    pix_ready_i <= ~pix_ready_i;
    if (pix_valid_o && pix_ready_i) got.push_back({pix_color_o, pix_y_o, pix_x_o});
    if (err_valid_o) n_err <= n_err + 1;
    if (err_valid_o) last_err <= err_code_o;
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic snd(input logic [2:0] o, input logic [11:0] f, input logic [31:0] p);
    csrf_issuer_inst.send(o, f, p);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata  <= d;
    do
    begin
      @(posedge sys_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do
    begin
      @(posedge sys_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", {er, ed}, {s_axi_rresp, s_axi_rdata});
    @(posedge sys_clk_i);
  endtask
  function automatic logic [30:0] cvt(input logic [31:0] p);
    return {p[31], p[23:16], p[23:22], p[15:8], p[15:14], p[7:0], p[7:6]};
  endfunction
  task automatic rect(input logic [15:0] x, y, w, h, input logic pt);
    logic [16:0] l, r, t, b;
    l = (x > cl) ? x : cl;
    r = ({1'b0, x} + w < cr) ? {1'b0, x} + w : cr;
    t = (y > ct) ? y : ct;
    b = ({1'b0, y} + h < cb) ? {1'b0, y} + h : cb;
    for (int j = t; j < b; j++)
      for (int i = l; i < r; i++) exp_q.push_back({fill, j[15:0], i[15:0]});
    if (pt)
      snd(3'h7, 12'h400, {y, x});
    else
    begin
      snd(3'h6, 12'h400, {y, x});
      snd(3'h6, 12'h404, {h, w});
    end
    @(negedge sys_clk_i);
    repeat (200) if (busy_o) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    chk("pixel count", exp_q.size(), got.size());
    foreach (exp_q[k]) chk("pixel", exp_q[k], got[k]);
    exp_q.delete();
    got.delete();
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    failures++;
    close_out;
  end
  initial
  begin
    {nrst_i, pix_ready_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, n_err} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(csrf_pkg::REG_CANVAS_MAX, 32'hffff_ffff);
    rd(8'h3c, 32'h0, csrf_pkg::RESP_SLVERR);
    wr(csrf_pkg::REG_WEIGHT, 32'h1, csrf_pkg::RESP_SLVERR);
    snd(3'h0, 12'h300, 32'h8123_4567);
    rd(csrf_pkg::REG_WEIGHT, 32'h0);
    snd(3'h0, 12'h300, 32'h7fff_ffff);
    rd(csrf_pkg::REG_WEIGHT, 32'h7f80_0000);
    snd(3'h1, 12'h300, 32'h5a);
    snd(3'h1, 12'h300, 32'h1ab);
    rd(csrf_pkg::REG_ROP, 32'h5a);
    chk("bad value code", 2'h2, last_err);
    n0 = n_err;
    for (int o = 0; o < 5; o++) snd(o[2:0], 12'h200, 32'h1);
    rd(csrf_pkg::REG_ROP, 32'h5a);
    chk("patch errors", 5, n_err - n0);
    chk("missing code", 2'h1, last_err);
    snd(3'h2, 12'h304, 32'h80ff_4001);
    snd(3'h3, 12'h304, 32'h0012_3456);
    chk("key color", cvt(32'h80ff_4001), pix_key_color_o);
    chk("plane color", cvt(32'h0012_3456), pix_plane_color_o);
    for (int m = 0; m < 8; m++)
    begin
      wr(csrf_pkg::REG_CTRL, {25'h0, m[2:0], 1'b0, m[1:0], 1'b0});
      chk("rop out", (m == 1 || m == 4) ? 8'h5a : 8'hcc, pix_rop_o);
      chk("enables", m[1:0], {pix_plane_en_o, pix_key_en_o});
    end
    wr(csrf_pkg::REG_CANVAS_MIN, 32'h0002_0003);
    wr(csrf_pkg::REG_CANVAS_MAX, 32'h0010_0010);
    snd(3'h4, 12'h300, 32'h0001_0001);
    snd(3'h4, 12'h304, 32'h0005_0006);
    rd(csrf_pkg::REG_UCLIP_MIN, 32'h0003_0004);
    rd(csrf_pkg::REG_UCLIP_MAX, 32'h0008_000a);
    snd(3'h5, 12'h300, 32'h1122_3344);
    rd(csrf_pkg::REG_CH_WEIGHT, 32'h1122_3344);
    rd(csrf_pkg::REG_CLIP_MIN, 32'h0002_0003);
    rd(csrf_pkg::REG_CLIP_MAX, 32'h0010_0010);
    wr(csrf_pkg::REG_CTRL, 32'h1);
    rd(csrf_pkg::REG_CLIP_MIN, 32'h0003_0004);
    rd(csrf_pkg::REG_CLIP_MAX, 32'h0008_000a);
    fill = 32'h00ab_cdef;
    wr(csrf_pkg::REG_FILL, fill);
    {cl, ct, cr, cb} = {16'h4, 16'h3, 16'ha, 16'h8};
    rect(16'h2, 16'h2, 16'h4, 16'h3, 1'b0);
    rect(16'h5, 16'h4, 16'h1, 16'h1, 1'b1);
    rect(16'h0, 16'h0, 16'h2, 16'h2, 1'b0);
    rect(16'h8, 16'h7, 16'h5, 16'h5, 1'b0);
    close_out;
  end
endmodule
